/* File: hw/aiow_pkg.sv */
// Package: timing constants and commands for the single-wire ID link
`default_nettype none
package aiow_pkg;
    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int CNT_W = 17;
    // ------------------------------------------------------------
    // Times in microseconds
    // ------------------------------------------------------------
    localparam int SLOT_US = 70;
    localparam int WSTRB_US = 5;
    localparam int WLOW0_US = 65;
    localparam int REC_US = 5;
    localparam int RSTRB_US = 5;
    localparam int HOST_RD_SAMPLE_US = 12;
    localparam int RST_US = 480;
    localparam int RREC_US = 480;
    localparam int PPD_MIN_US = 15;
    localparam int BURN_US = 2500;
    localparam int BSU_US = 5;
    localparam int BREC_US = 5;
    localparam int DEV_SAMPLE_US = 30;
    localparam int RD_REL_US = 30;
    localparam int PPD_US = 30;
    localparam int PP_US = 120;
    // ------------------------------------------------------------
    // Cycle counts (whole microseconds at 25 MHz divide exactly)
    // ------------------------------------------------------------
    localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
    localparam int WSTRB_CYC = WSTRB_US * CLK_MHZ;
    localparam int WLOW0_CYC = WLOW0_US * CLK_MHZ;
    localparam int REC_CYC = REC_US * CLK_MHZ;
    localparam int RSTRB_CYC = RSTRB_US * CLK_MHZ;
    localparam int HOST_RD_SAMPLE_CYC = HOST_RD_SAMPLE_US * CLK_MHZ;
    localparam int PPD_MIN_CYC = PPD_MIN_US * CLK_MHZ;
    localparam int BSU_CYC = BSU_US * CLK_MHZ;
    localparam int BREC_CYC = BREC_US * CLK_MHZ;
    localparam int DEV_SAMPLE_CYC = DEV_SAMPLE_US * CLK_MHZ;
    localparam int RD_REL_CYC = RD_REL_US * CLK_MHZ;
    localparam int PPD_CYC = PPD_US * CLK_MHZ;
    localparam int PP_CYC = PP_US * CLK_MHZ;
    // ------------------------------------------------------------
    // Host commands
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_RESET = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_READ = 2'h2,
        CMD_BURN = 2'h3
    } aiow_cmd_e;
endpackage
`default_nettype wire

/* File: hw/aiow_if.sv */
// Interface: the open-drain auth_id_wire shared by host and device
`default_nettype none
interface aiow_if;
    logic host_out;
    logic host_oe_n;
    logic dev_out;
    logic dev_oe_n;
    logic level;
    // Wired-AND with pull-up: any enabled low driver wins
    assign level = ~((~host_oe_n & ~host_out) | (~dev_oe_n & ~dev_out));
    modport host (output host_out, output host_oe_n, input level);
    modport device (output dev_out, output dev_oe_n, input level);
endinterface
`default_nettype wire

/* File: hw/aiow_device.sv */
// Device end: presence answer, write-bit sampling, read-bit drive
`default_nettype none
module aiow_device
    import aiow_pkg::*;
#(
    parameter int RST_CYC = RST_US * CLK_MHZ
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    aiow_if.device link,
    input wire logic read_mode_in,
    input wire logic tx_bit_in,
    output logic tx_taken_out,
    output logic rx_bit_out,
    output logic rx_valid_out,
    output logic reset_seen_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        D_IDLE = 4'h1,
        D_SLOT = 4'h2,
        D_PDLY = 4'h4,
        D_PRES = 4'h8
    } aiow_dstate_e;

    aiow_dstate_e state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic level_reg;
    logic rd_reg, rd_next;
    logic bit_reg, bit_next;
    logic drive_reg, drive_next;
    logic rx_bit_reg, rx_bit_next;
    logic rx_valid_reg, rx_valid_next;
    logic taken_reg, taken_next;
    logic rst_seen_reg, rst_seen_next;

    wire fall = level_reg & ~link.level;
    wire rise = ~level_reg & link.level;
    wire cnt_sat = (cnt_reg == CNT_W'(RST_CYC));
    wire [CNT_W-1:0] cnt_inc = cnt_sat ? cnt_reg : cnt_reg + 1'b1;
    // Count starts one cycle after the fall, so a full-length pulse reads one short
    wire is_reset = (cnt_reg >= CNT_W'(RST_CYC - 1)); // see R9
    wire sample_pt = (cnt_reg == CNT_W'(DEV_SAMPLE_CYC - 1));
    wire rd_release = (cnt_reg >= CNT_W'(RD_REL_CYC - 1));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_inc;
        rd_next = rd_reg;
        bit_next = bit_reg;
        drive_next = 1'b0;
        rx_bit_next = rx_bit_reg;
        rx_valid_next = 1'b0;
        taken_next = 1'b0;
        rst_seen_next = 1'b0;
        case (state_reg)
            D_IDLE: begin
                cnt_next = '0;
                if (fall) begin
                    state_next = D_SLOT;
                    rd_next = read_mode_in;
                    bit_next = tx_bit_in;
                    taken_next = read_mode_in;
                    // Line already low, so driving at once meets the earliest point
                    drive_next = read_mode_in & ~tx_bit_in; // see R7
                end
            end
            D_SLOT: begin
                // Held past the 17 us floor, dropped well before 60 us
                drive_next = rd_reg & ~bit_reg & ~rd_release; // see R8
                if (sample_pt && !rd_reg) begin
                    // Between setup end (15 us) and hold floor (60 us)
                    rx_bit_next = link.level; // see R16
                    rx_valid_next = 1'b1;
                end
                if (link.level && is_reset) begin
                    state_next = D_PDLY;
                    cnt_next = '0;
                    rst_seen_next = 1'b1;
                end else if (link.level && rd_release) begin
                    state_next = D_IDLE;
                end
            end
            D_PDLY: begin
                if (cnt_reg == CNT_W'(PPD_CYC - 1)) begin // see R10
                    state_next = D_PRES;
                    cnt_next = '0;
                    drive_next = 1'b1;
                end
            end
            D_PRES: begin
                drive_next = 1'b1; // see R11
                if (cnt_reg == CNT_W'(PP_CYC - 1)) begin
                    state_next = D_IDLE;
                    drive_next = 1'b0;
                end
            end
            default: begin
                state_next = D_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= D_IDLE;
            cnt_reg <= '0;
            level_reg <= 1'b1;
            rd_reg <= 1'b0;
            bit_reg <= 1'b1;
            drive_reg <= 1'b0;
            rx_bit_reg <= 1'b0;
            rx_valid_reg <= 1'b0;
            taken_reg <= 1'b0;
            rst_seen_reg <= 1'b0;
        end else if (ce_in) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            level_reg <= link.level;
            rd_reg <= rd_next;
            bit_reg <= bit_next;
            drive_reg <= drive_next;
            rx_bit_reg <= rx_bit_next;
            rx_valid_reg <= rx_valid_next;
            taken_reg <= taken_next;
            rst_seen_reg <= rst_seen_next;
        end
    end

    assign link.dev_out = 1'b0;
    assign link.dev_oe_n = ~drive_reg;
    assign tx_taken_out = taken_reg;
    assign rx_bit_out = rx_bit_reg;
    assign rx_valid_out = rx_valid_reg;
    assign reset_seen_out = rst_seen_reg;
endmodule
`default_nettype wire

/* File: hw/aiow_host.sv */
// Host end: reset, write and read slots on the ID wire, burn pulses on burn_en_out
// ------------------------------------------------------------
// Notes on behaviour
// R1: Each slot lasts 60 to 120 us.
// R2: Write strobe low 1 to 15 us.
// R3: Write level set by 15 us.
// R4: Write level held 60 us, inside slot.
// R5: Line released 5 us between slots.
// R6: Read strobe low 1 to 13 us.
// R7: Device drives read bit by 13 us.
// R8: Device holds bit 17 us, releases by 60.
// R9: Reset pulse low at least 480 us.
// R10: Presence starts 15 to 60 us later.
// R11: Presence lasts 60 to 240 us.
// R12: Reset recovery 480 us before first slot.
// R13: Burn pulse lasts at least 2500 us.
// R14: Burn setup at least 5 us.
// R15: Burn recovery at least 5 us.
// R16: Device samples write bit once, mid-window.
// ------------------------------------------------------------
`default_nettype none
module aiow_host
    import aiow_pkg::*;
#(
    parameter int RST_CYC = RST_US * CLK_MHZ,
    parameter int RREC_CYC = RREC_US * CLK_MHZ,
    parameter int BURN_CYC = BURN_US * CLK_MHZ
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    aiow_if.host link,
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_in,
    input wire logic wr_bit_in,
    output logic cmd_ready_out,
    output logic rd_bit_out,
    output logic rd_valid_out,
    output logic presence_out,
    output logic burn_en_out,
    output logic done_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        H_IDLE = 9'h001,
        H_RST = 9'h002,
        H_RREC = 9'h004,
        H_LOW = 9'h008,
        H_REL = 9'h010,
        H_REC = 9'h020,
        H_BSU = 9'h040,
        H_BURN = 9'h080,
        H_BREC = 9'h100
    } aiow_hstate_e;

    aiow_hstate_e state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] low_len_reg, low_len_next;
    logic is_rd_reg, is_rd_next;
    logic oe_n_reg;
    logic rd_bit_reg, rd_bit_next;
    logic rd_valid_reg, rd_valid_next;
    logic pres_hit_reg, pres_hit_next;
    logic pres_reg, pres_next;
    logic burn_reg, burn_next;
    logic done_reg, done_next;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire take = cmd_valid_in & (state_reg == H_IDLE);
    wire [CNT_W-1:0] cnt_inc = cnt_reg + 1'b1;
    wire low_end = (cnt_reg == low_len_reg - 1'b1);
    wire slot_end = (cnt_reg == CNT_W'(SLOT_CYC - 1));
    wire rd_sample = (cnt_reg == CNT_W'(HOST_RD_SAMPLE_CYC - 1));
    wire rec_end = (cnt_reg == CNT_W'(REC_CYC - 1));
    wire rst_end = (cnt_reg == CNT_W'(RST_CYC - 1));
    wire rrec_end = (cnt_reg == CNT_W'(RREC_CYC - 1));
    wire pres_win = (cnt_reg >= CNT_W'(PPD_MIN_CYC));
    wire bsu_end = (cnt_reg == CNT_W'(BSU_CYC - 1));
    wire burn_end = (cnt_reg == CNT_W'(BURN_CYC - 1));
    wire brec_end = (cnt_reg == CNT_W'(BREC_CYC - 1));
    // Write 0 stays low through the hold; write 1 is strobe then release
    wire [CNT_W-1:0] wr_len = wr_bit_in ? CNT_W'(WSTRB_CYC) : CNT_W'(WLOW0_CYC); // see R2 R3 R4
    wire drive_next = (state_next == H_RST) | (state_next == H_LOW);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_inc;
        low_len_next = low_len_reg;
        is_rd_next = is_rd_reg;
        rd_bit_next = rd_bit_reg;
        rd_valid_next = 1'b0;
        pres_hit_next = pres_hit_reg;
        pres_next = pres_reg;
        burn_next = 1'b0;
        done_next = 1'b0;
        case (state_reg)
            H_IDLE: begin
                cnt_next = '0;
                if (take) begin
                    case (cmd_in)
                        CMD_RESET: begin
                            state_next = H_RST; // see R9
                        end
                        CMD_WRITE: begin
                            state_next = H_LOW;
                            is_rd_next = 1'b0;
                            low_len_next = wr_len;
                        end
                        CMD_READ: begin
                            state_next = H_LOW;
                            is_rd_next = 1'b1;
                            low_len_next = CNT_W'(RSTRB_CYC); // see R6
                        end
                        default: begin
                            state_next = H_BSU; // see R14
                        end
                    endcase
                end
            end
            H_RST: begin
                if (rst_end) begin
                    state_next = H_RREC;
                    cnt_next = '0;
                    pres_hit_next = 1'b0;
                end
            end
            H_RREC: begin
                // Any low after the earliest presence start counts
                if (pres_win && !link.level) begin
                    pres_hit_next = 1'b1;
                end
                if (rrec_end) begin // see R12
                    state_next = H_IDLE;
                    pres_next = pres_hit_reg | (pres_win & ~link.level);
                    done_next = 1'b1;
                end
            end
            H_LOW: begin
                if (low_end) begin
                    state_next = H_REL;
                end
            end
            H_REL: begin
                // Late enough for the device to be driving, before its floor
                if (is_rd_reg && rd_sample) begin
                    rd_bit_next = link.level;
                    rd_valid_next = 1'b1;
                end
                if (slot_end) begin // see R1
                    state_next = H_REC;
                    cnt_next = '0;
                end
            end
            H_REC: begin
                if (rec_end) begin // see R5
                    state_next = H_IDLE;
                    done_next = 1'b1;
                end
            end
            H_BSU: begin
                if (bsu_end) begin
                    state_next = H_BURN;
                    cnt_next = '0;
                    burn_next = 1'b1;
                end
            end
            H_BURN: begin
                burn_next = 1'b1; // see R13
                if (burn_end) begin
                    state_next = H_BREC;
                    cnt_next = '0;
                    burn_next = 1'b0;
                end
            end
            H_BREC: begin
                if (brec_end) begin // see R15
                    state_next = H_IDLE;
                    done_next = 1'b1;
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= H_IDLE;
            cnt_reg <= '0;
            low_len_reg <= '0;
            is_rd_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            rd_bit_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            pres_hit_reg <= 1'b0;
            pres_reg <= 1'b0;
            burn_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce_in) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            low_len_reg <= low_len_next;
            is_rd_reg <= is_rd_next;
            oe_n_reg <= ~drive_next;
            rd_bit_reg <= rd_bit_next;
            rd_valid_reg <= rd_valid_next;
            pres_hit_reg <= pres_hit_next;
            pres_reg <= pres_next;
            burn_reg <= burn_next;
            done_reg <= done_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain: only ever pulls low, enable is the sole control
    assign link.host_out = 1'b0;
    assign link.host_oe_n = oe_n_reg;
    assign cmd_ready_out = (state_reg == H_IDLE);
    assign rd_bit_out = rd_bit_reg;
    assign rd_valid_out = rd_valid_reg;
    assign presence_out = pres_reg;
    assign burn_en_out = burn_reg;
    assign done_out = done_reg;
endmodule
`default_nettype wire

/* File: dv/aiow_asserts.sv */
// Checker: slot timing assertions on the shared ID wire
`default_nettype none
module aiow_asserts
    import aiow_pkg::*;
#(
    parameter int RST_CYC = RST_US * CLK_MHZ,
    parameter int RREC_CYC = RREC_US * CLK_MHZ
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic host_oe_n,
    input wire logic dev_oe_n,
    input wire logic level
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SAT = 100000;
    int host_low;
    int dev_low;
    int hi_cnt;
    int since_fall;
    int since_rst;
    int since_hfall;
    logic rd_drv;
    function automatic int inc(input int v);
        return (v >= SAT) ? SAT : v + 1;
    endfunction
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Saturate so long idle spans never wrap into a false pass
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            host_low <= 0;
            dev_low <= 0;
            hi_cnt <= SAT;
            since_fall <= SAT;
            since_rst <= SAT;
            since_hfall <= SAT;
            rd_drv <= 1'b0;
        end else begin
            host_low <= host_oe_n ? 0 : inc(host_low);
            dev_low <= dev_oe_n ? 0 : inc(dev_low);
            hi_cnt <= level ? inc(hi_cnt) : 0;
            since_fall <= (!level && hi_cnt != 0) ? 0 : inc(since_fall);
            since_rst <= (host_oe_n && host_low >= RST_CYC) ? 0 : inc(since_rst);
            since_hfall <= (!host_oe_n && host_low == 0) ? 0 : inc(since_hfall);
            // Device low that began on an already low line is a read bit, not presence
            rd_drv <= dev_oe_n ? 1'b0 : ((dev_low == 0) ? (hi_cnt == 0) : rd_drv);
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_slot_length: assert property (
        $fell(host_oe_n) |-> since_hfall >= 1500) else $error("slot too short");
    a_strobe_short: assert property (
        $rose(host_oe_n) && host_low < 1500 |-> host_low >= 25 && host_low <= 325)
        else $error("start strobe width out of range");
    a_long_low: assert property (
        $rose(host_oe_n) && host_low > 325
        |-> (host_low >= 1500 && host_low <= 2875) || host_low >= RST_CYC - 1)
        else $error("long host low out of range");
    a_slot_recovery: assert property (
        $fell(host_oe_n) |-> hi_cnt >= REC_CYC - 2) else $error("recovery too short");
    a_read_drive: assert property (
        $fell(dev_oe_n) && hi_cnt == 0 |-> since_fall <= 325)
        else $error("read bit driven late");
    a_read_hold: assert property (
        $rose(dev_oe_n) |-> since_fall >= 425) else $error("device released too early");
    a_read_release: assert property (
        rd_drv |-> since_fall < 1500)
        else $error("read bit not released in time");
    a_presence_delay: assert property (
        $fell(dev_oe_n) && hi_cnt != 0 |-> hi_cnt >= 375 && hi_cnt <= 1500)
        else $error("presence delay out of range");
    a_presence_width: assert property (
        $rose(dev_oe_n) && dev_low > 900 |-> dev_low >= 1500 && dev_low <= 6000)
        else $error("presence width out of range");
    a_reset_recovery: assert property (
        $fell(host_oe_n) |-> since_rst >= RREC_CYC - 2) else $error("reset recovery short");
    c_presence: cover property ($fell(dev_oe_n) && hi_cnt != 0);
    c_read_zero: cover property ($fell(dev_oe_n) && hi_cnt == 0);
    c_write_zero: cover property ($rose(host_oe_n) && host_low > 1500 && host_low < 3000);
endmodule
`default_nettype wire

/* File: dv/auth_id_one_wire_slots_bench.sv */
// Testbench: host and device ends joined on one ID wire
`default_nettype none
module auth_id_one_wire_slots_bench
    import aiow_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RST_T = 12000;
    localparam int RREC_T = 12000;
    localparam int BURN_T = 200;
    localparam int XFER = SLOT_CYC + REC_CYC;
    logic clk_in, rst_in, ce, cmd_valid, wr_bit, read_mode, tx_bit, rd_got;
    logic [1:0] cmd;
    logic cmd_ready, rd_bit, rd_valid, presence, burn_en, done;
    logic tx_taken, rx_bit, rx_valid, reset_seen;
    int error_cnt, checks, lat, rx_cnt, taken_cnt, seen_cnt, burn_cnt, hl, last_hl, dl, last_dl;
    logic wbits [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic rbits [3] = '{1'b0, 1'b1, 1'b0};
    aiow_if link_if ();
    aiow_host #(.RST_CYC(RST_T), .RREC_CYC(RREC_T), .BURN_CYC(BURN_T)) u_aiow_host (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .link(link_if),
        .cmd_valid_in(cmd_valid), .cmd_in(cmd), .wr_bit_in(wr_bit),
        .cmd_ready_out(cmd_ready), .rd_bit_out(rd_bit), .rd_valid_out(rd_valid),
        .presence_out(presence), .burn_en_out(burn_en), .done_out(done));
    aiow_device #(.RST_CYC(RST_T)) u_aiow_device (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .link(link_if),
        .read_mode_in(read_mode), .tx_bit_in(tx_bit), .tx_taken_out(tx_taken),
        .rx_bit_out(rx_bit), .rx_valid_out(rx_valid), .reset_seen_out(reset_seen));
    aiow_asserts #(.RST_CYC(RST_T), .RREC_CYC(RREC_T)) u_aiow_asserts (
        .clk_in(clk_in), .rst_in(rst_in), .host_oe_n(link_if.host_oe_n),
        .dev_oe_n(link_if.dev_oe_n), .level(link_if.level));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // ------------------------------------------------------------
    // Wire and pulse monitor
    // ------------------------------------------------------------
    // Sampled 1 ns after the edge so registered pulses have landed
    always @(posedge clk_in) begin
        #1;
        rx_cnt += (rx_valid === 1'b1);
        taken_cnt += (tx_taken === 1'b1);
        seen_cnt += (reset_seen === 1'b1);
        burn_cnt += (burn_en === 1'b1);
        if (link_if.host_oe_n === 1'b0) hl++;
        else if (hl != 0) begin
            last_hl = hl;
            hl = 0;
        end
        if (link_if.dev_oe_n === 1'b0) dl++;
        else if (dl != 0) begin
            last_dl = dl;
            dl = 0;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("Counts: checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Request held from one falling edge through the taking rising edge
    task automatic run_cmd(input logic [1:0] c, input logic b);
        int n;
        n = 0;
        @(negedge clk_in);
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        cmd_valid = 1'b1;
        cmd = c;
        wr_bit = b;
        read_mode = (c == CMD_READ);
        tx_bit = b;
        rd_got = 1'bx;
        @(negedge clk_in);
        cmd_valid = 1'b0;
        lat = 0;
        do begin
            @(posedge clk_in);
            lat++;
            #1;
            if (rd_valid === 1'b1) rd_got = rd_bit;
        end while (done !== 1'b1 && lat < 30000);
        chk(done, 1'b1);
    endtask
    initial begin
        repeat (70000) @(posedge clk_in);
        error_cnt++;
        conclude();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_in, ce} = 2'h3;
        {cmd_valid, wr_bit, read_mode, tx_bit} = 4'h0;
        cmd = CMD_RESET;
        {error_cnt, checks, rx_cnt, taken_cnt, seen_cnt, burn_cnt} = '0;
        {hl, last_hl, dl, last_dl} = '0;
        repeat (3) @(negedge clk_in);
        rst_in = 1'b0;
        run_cmd(CMD_RESET, 1'b0);
        chk(lat, RST_T + RREC_T);
        chk(presence, 1'b1);
        chk(seen_cnt, 1);
        chk(last_dl, PP_CYC);
        // Reset low also crosses the write sample point
        rx_cnt = 0;
        foreach (wbits[i]) begin
            run_cmd(CMD_WRITE, wbits[i]);
            chk(lat, XFER);
            chk(last_hl, wbits[i] ? WSTRB_CYC : WLOW0_CYC);
            chk(rx_bit, wbits[i]);
        end
        chk(rx_cnt, 5);
        foreach (rbits[i]) begin
            run_cmd(CMD_READ, rbits[i]);
            chk(rd_got, rbits[i]);
            chk(last_hl, RSTRB_CYC);
        end
        chk(taken_cnt, 3);
        run_cmd(CMD_BURN, 1'b0);
        chk(lat, BSU_CYC + BURN_T + BREC_CYC);
        chk(burn_cnt, BURN_T);
        // Freeze both ends mid-slot; the slot must stretch, not break
        fork
            run_cmd(CMD_WRITE, 1'b0);
            begin
                repeat (600) @(negedge clk_in);
                ce = 1'b0;
                repeat (100) @(negedge clk_in);
                ce = 1'b1;
            end
        join
        chk(lat, XFER + 100);
        chk(rx_bit, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
